//--- rtl/rfc_defs.svh
/*
  constants for the register-file core: register indices, status bits,
  step sizes, masks and constant generator values.
  assumes inclusion by bare name from rtl and verification files.
*/
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH
`define RFC_IDX_PC 4'h0
`define RFC_IDX_SP 4'h1
`define RFC_IDX_SR 4'h2
`define RFC_IDX_CG 4'h3
`define RFC_SR_C 0
`define RFC_SR_Z 1
`define RFC_SR_N 2
`define RFC_SR_V 8
`define RFC_SR_MASK 16'h01FF
`define RFC_PC_STEP 16'h0002
`define RFC_WORD_STEP 16'h0002
`define RFC_BYTE_STEP 16'h0001
`define RFC_BYTE_MASK 16'h00FF
`define RFC_CG_0 16'h0000
`define RFC_CG_1 16'h0001
`define RFC_CG_2 16'h0002
`define RFC_CG_4 16'h0004
`define RFC_CG_8 16'h0008
`define RFC_CG_M1 16'hFFFF
`define RFC_RESET_VAL 16'h0000
`endif

//--- rtl/rfc_pkg.sv
/*
  types for the register-file core.
  assumes rfc_defs.svh is available on the include path.
*/
`default_nettype none
package rfc_pkg;
  // instruction format
  typedef enum logic [1:0] {
    RFC_FMT_DUAL = 2'b00,
    RFC_FMT_SINGLE = 2'b01,
    RFC_FMT_JUMP = 2'b10,
    RFC_FMT_NONE = 2'b11
  } rfc_fmt_t;
  // source modes; destination uses the first four only
  typedef enum logic [2:0] {
    RFC_AM_REG = 3'b000,
    RFC_AM_IDX = 3'b001,
    RFC_AM_SYM = 3'b010,
    RFC_AM_ABS = 3'b011,
    RFC_AM_IND = 3'b100,
    RFC_AM_INC = 3'b101,
    RFC_AM_IMM = 3'b110,
    RFC_AM_BAD = 3'b111
  } rfc_am_t;
  typedef enum logic [3:0] {
    RFC_OP_MOV = 4'h0, RFC_OP_ADD = 4'h1, RFC_OP_ADDC = 4'h2, RFC_OP_SUBC = 4'h3,
    RFC_OP_SUB = 4'h4, RFC_OP_CMP = 4'h5, RFC_OP_DADD = 4'h6, RFC_OP_BIT = 4'h7,
    RFC_OP_BIC = 4'h8, RFC_OP_BIS = 4'h9, RFC_OP_XOR = 4'hA, RFC_OP_AND = 4'hB,
    RFC_OP_RRC = 4'hC, RFC_OP_SWPB = 4'hD, RFC_OP_RRA = 4'hE, RFC_OP_SXT = 4'hF
  } rfc_op_t;
endpackage
`default_nettype wire

//--- rtl/rfc_alu.sv
/*
  combinational alu of the register-file core, word or byte width.
  assumes operands already selected; flags returned for the status slot.
*/
`default_nettype none
`include "rfc_defs.svh"
module rfc_alu
  import rfc_pkg::*;
(
  input wire rfc_op_t op,
  input wire logic byteMode,
  input wire logic [15:0] srcVal,
  input wire logic [15:0] dstVal,
  input wire logic carryIn,
  output logic [15:0] result,
  output logic [3:0] flags,
  output logic writes
);
  logic [16:0] sum;
  logic [15:0] raw;
  logic cOut;
  logic msb;
  logic ovf;
  logic sMsb;
  logic dMsb;
  always_comb begin
    sum = 17'h0_0000;
    raw = dstVal;
    cOut = carryIn;
    ovf = 1'b0;
    writes = 1'b1;
    sMsb = byteMode ? srcVal[7] : srcVal[15];
    dMsb = byteMode ? dstVal[7] : dstVal[15];
    case (op)
      RFC_OP_MOV: raw = srcVal;
      RFC_OP_ADD, RFC_OP_ADDC, RFC_OP_DADD: begin
        sum = {1'b0, dstVal} + {1'b0, srcVal} + {16'h0000, op != RFC_OP_ADD && carryIn};
        raw = sum[15:0];
      end
      RFC_OP_SUB, RFC_OP_SUBC, RFC_OP_CMP: begin
        sum = {1'b0, dstVal} + {1'b0, ~srcVal} + {16'h0000, op != RFC_OP_SUBC || carryIn};
        raw = sum[15:0];
        writes = op != RFC_OP_CMP;
      end
      RFC_OP_BIT, RFC_OP_AND: begin
        raw = srcVal & dstVal;
        writes = op == RFC_OP_AND;
      end
      RFC_OP_BIC: raw = dstVal & ~srcVal;
      RFC_OP_BIS: raw = dstVal | srcVal;
      RFC_OP_XOR: raw = dstVal ^ srcVal;
      RFC_OP_RRC: raw = byteMode ? {8'h00, carryIn, dstVal[7:1]} : {carryIn, dstVal[15:1]};
      RFC_OP_RRA: raw = byteMode ? {8'h00, dstVal[7], dstVal[7:1]} : {dstVal[15], dstVal[15:1]};
      RFC_OP_SWPB: raw = {dstVal[7:0], dstVal[15:8]};
      RFC_OP_SXT: raw = {{8{dstVal[7]}}, dstVal[7:0]};
      default: raw = dstVal;
    endcase
    if (byteMode && op != RFC_OP_SWPB && op != RFC_OP_SXT) begin
      raw = raw & `RFC_BYTE_MASK;
    end
    msb = byteMode ? raw[7] : raw[15];
    case (op)
      RFC_OP_ADD, RFC_OP_ADDC, RFC_OP_DADD: begin
        cOut = byteMode ? (dstVal[7:0] + srcVal[7:0] + {7'h00, op != RFC_OP_ADD && carryIn}) > 9'h0FF : sum[16];
        ovf = (sMsb == dMsb) && (msb != dMsb);
      end
      RFC_OP_SUB, RFC_OP_SUBC, RFC_OP_CMP: begin
        cOut = byteMode ? dstVal[7:0] >= srcVal[7:0] : sum[16];
        ovf = (sMsb != dMsb) && (msb != dMsb);
      end
      RFC_OP_RRC, RFC_OP_RRA: cOut = dstVal[0];
      RFC_OP_MOV: cOut = carryIn;
      default: cOut = raw != 16'h0000;
    endcase
    result = raw;
    flags = {ovf, msb, raw == 16'h0000, cOut};
  end
endmodule
`default_nettype wire

//--- rtl/rfc_core.sv
/*
  register-file and operand core of a small 16-bit risc processor:
  sixteen registers, two read ports, one write port, constant generator.
  assumes an outside sequencer supplies decoded fields and memory operands.
*/
// Operation
// - all registers and datapath are 16 bits
// - sixteen registers selected by 4-bit index
// - register-to-register op completes in one cycle
// - index 0..3: pc, sp, status, constants
// - indices 4..15 plain general storage
// - seven source and four destination modes
// - non-jump instructions are register ops plus modes
// - alu covers sixteen operations, three formats
// - word or byte width, except SWPB and SXT which give a full word
// - peripherals reached over shared buses as operands
// - formats: dual, single, relative jump
`default_nettype none
`include "rfc_defs.svh"
module rfc_core
  import rfc_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int REG_N = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instValid,
  input wire rfc_fmt_t fmt,
  input wire rfc_op_t op,
  input wire logic byteMode,
  input wire logic [3:0] srcIdx,
  input wire logic [3:0] dstIdx,
  input wire rfc_am_t srcMode,
  input wire rfc_am_t dstMode,
  input wire logic [1:0] cgSel,
  input wire logic [DATA_W-1:0] extWord,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic [2:0] jumpCond,
  input wire logic [9:0] jumpOffset,
  output logic [DATA_W-1:0] busAddr,
  output logic [DATA_W-1:0] busWdata,
  output logic busWrite,
  output logic busByte,
  output logic [DATA_W-1:0] pcOut,
  output logic [DATA_W-1:0] statusOut,
  output logic modeError
);
  logic [DATA_W-1:0] regs [REG_N];
  logic [DATA_W-1:0] rdA;
  logic [DATA_W-1:0] rdB;
  logic [DATA_W-1:0] srcVal;
  logic [DATA_W-1:0] dstVal;
  logic [DATA_W-1:0] cgVal;
  logic [DATA_W-1:0] result;
  logic [3:0] flags;
  logic aluWrites;
  logic useCg;
  logic srcMem;
  logic dstMem;
  logic jumpTaken;
  logic next_busWrite;
  logic [DATA_W-1:0] next_busAddr;
  logic [DATA_W-1:0] next_pc;
  logic [DATA_W-1:0] stepVal;
  logic [DATA_W-1:0] jumpDisp;
  logic [DATA_W-1:0] next_status;
  logic execOk;
  logic illegalMode;

  // two combinational read ports keep reg-reg ops single cycle
  assign rdA = regs[srcIdx];
  assign rdB = regs[dstIdx];

  // constants come from index 3, or status index when cgSel[1] is set
  always_comb begin
    useCg = 1'b0;
    cgVal = `RFC_CG_0;
    if (srcIdx == `RFC_IDX_CG) begin
      useCg = 1'b1;
      case (cgSel)
        2'b00: cgVal = `RFC_CG_0;
        2'b01: cgVal = `RFC_CG_1;
        2'b10: cgVal = `RFC_CG_2;
        default: cgVal = `RFC_CG_M1;
      endcase
    end else if (srcIdx == `RFC_IDX_SR && cgSel[1]) begin
      useCg = 1'b1;
      cgVal = cgSel[0] ? `RFC_CG_8 : `RFC_CG_4;
    end
  end

  assign srcMem = srcMode != RFC_AM_REG && srcMode != RFC_AM_IMM && !useCg;
  assign dstMem = fmt != RFC_FMT_JUMP && dstMode != RFC_AM_REG;
  assign stepVal = byteMode ? `RFC_BYTE_STEP : `RFC_WORD_STEP;
  assign execOk = instValid && fmt != RFC_FMT_NONE;

  // a bad source mode, or a bad destination mode in dual format, is flagged and kept off the bus,
  // so a garbled dual-format instruction cannot scribble over peripheral space
  always_comb begin
    illegalMode = 1'b0;
    if (srcMode == RFC_AM_BAD) begin
      illegalMode = 1'b1;
    end else if (fmt == RFC_FMT_DUAL && dstMode > RFC_AM_ABS) begin
      illegalMode = 1'b1;
    end
  end

  // seven source modes select register, constant, immediate or bus data
  always_comb begin
    case (srcMode)
      RFC_AM_REG: srcVal = useCg ? cgVal : rdA;
      RFC_AM_IMM: srcVal = extWord;
      RFC_AM_IDX, RFC_AM_SYM, RFC_AM_ABS, RFC_AM_IND, RFC_AM_INC: srcVal = useCg ? cgVal : memRdata;
      default: srcVal = rdA;
    endcase
    if (byteMode) begin
      srcVal = srcVal & `RFC_BYTE_MASK;
    end
  end
  assign dstVal = dstMem ? memRdata : rdB;

  rfc_alu u_alu (
    .op(op),
    .byteMode(byteMode),
    .srcVal(fmt == RFC_FMT_SINGLE ? dstVal : srcVal),
    .dstVal(dstVal),
    .carryIn(regs[`RFC_IDX_SR][`RFC_SR_C]),
    .result(result),
    .flags(flags),
    .writes(aluWrites)
  );

  // relative jump conditions on status flags
  always_comb begin
    case (jumpCond)
      3'b000: jumpTaken = !regs[`RFC_IDX_SR][`RFC_SR_Z];
      3'b001: jumpTaken = regs[`RFC_IDX_SR][`RFC_SR_Z];
      3'b010: jumpTaken = !regs[`RFC_IDX_SR][`RFC_SR_C];
      3'b011: jumpTaken = regs[`RFC_IDX_SR][`RFC_SR_C];
      3'b100: jumpTaken = regs[`RFC_IDX_SR][`RFC_SR_N];
      3'b101: jumpTaken = regs[`RFC_IDX_SR][`RFC_SR_N] == regs[`RFC_IDX_SR][`RFC_SR_V];
      3'b110: jumpTaken = regs[`RFC_IDX_SR][`RFC_SR_N] != regs[`RFC_IDX_SR][`RFC_SR_V];
      default: jumpTaken = 1'b1;
    endcase
  end
  assign jumpDisp = {{5{jumpOffset[9]}}, jumpOffset, 1'b0};

  always_comb begin
    next_pc = regs[`RFC_IDX_PC] + `RFC_PC_STEP;
    if (fmt == RFC_FMT_JUMP && jumpTaken) begin
      next_pc = next_pc + jumpDisp;
    end
  end

  // memory destination: address from register or pc plus extension word, or extension word alone
  always_comb begin
    next_busWrite = execOk && dstMem && aluWrites && !illegalMode;
    case (dstMode)
      RFC_AM_IDX: next_busAddr = rdB + extWord;
      RFC_AM_SYM: next_busAddr = regs[`RFC_IDX_PC] + extWord;
      default: next_busAddr = extWord;
    endcase
  end

  // flags land in their own bit positions; the other status bits keep their value
  always_comb begin
    next_status = regs[`RFC_IDX_SR];
    next_status[`RFC_SR_C] = flags[0];
    next_status[`RFC_SR_Z] = flags[1];
    next_status[`RFC_SR_N] = flags[2];
    next_status[`RFC_SR_V] = flags[3];
  end

  // single write port, plus the pc/status/autoincrement side effects
  genvar g;
  generate
    for (g = 0; g < REG_N; g++) begin : gReg
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          regs[g] <= `RFC_RESET_VAL;
        end else if (execOk) begin
          if (g == `RFC_IDX_PC) begin
            regs[g] <= (!dstMem && dstIdx == 4'(g) && aluWrites && fmt != RFC_FMT_JUMP) ? result : next_pc;
          end else if (g == `RFC_IDX_CG) begin
            regs[g] <= `RFC_RESET_VAL;
          end else if (!dstMem && dstIdx == 4'(g) && aluWrites && fmt != RFC_FMT_JUMP) begin
            regs[g] <= (g == `RFC_IDX_SR) ? (result & `RFC_SR_MASK) : result;
          end else if (g == `RFC_IDX_SR && fmt != RFC_FMT_JUMP && op != RFC_OP_MOV) begin
            regs[g] <= next_status;
          end else if (srcMode == RFC_AM_INC && srcIdx == 4'(g) && !useCg) begin
            regs[g] <= regs[g] + stepVal;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busWrite <= 1'b0;
      busAddr <= `RFC_RESET_VAL;
      busWdata <= `RFC_RESET_VAL;
      busByte <= 1'b0;
      modeError <= 1'b0;
    end else begin
      busWrite <= next_busWrite;
      busAddr <= srcMem && !next_busWrite ? (srcMode == RFC_AM_IND || srcMode == RFC_AM_INC ? rdA : extWord) : next_busAddr;
      busWdata <= result;
      busByte <= byteMode;
      modeError <= execOk && illegalMode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pcOut <= `RFC_RESET_VAL;
      statusOut <= `RFC_RESET_VAL;
    end else begin
      pcOut <= regs[`RFC_IDX_PC];
      statusOut <= regs[`RFC_IDX_SR];
    end
  end
endmodule
`default_nettype wire

//--- verification/rfc_core_properties.sv
/*
  concurrent checks on the register-file core ports.
  assumes rfc_pkg is compiled first and rfc_defs.svh is on the include path.
*/
`default_nettype none
`include "rfc_defs.svh"
module rfc_core_properties
  import rfc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instValid,
  input wire rfc_fmt_t fmt,
  input wire logic byteMode,
  input wire logic [3:0] dstIdx,
  input wire rfc_am_t srcMode,
  input wire rfc_am_t dstMode,
  input wire logic [DATA_W-1:0] busWdata,
  input wire logic busWrite,
  input wire logic busByte,
  input wire logic [DATA_W-1:0] pcOut,
  input wire logic [DATA_W-1:0] statusOut,
  input wire logic modeError
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_idle;
    !instValid || fmt == RFC_FMT_NONE;
  endsequence
  sequence s_dual;
    instValid && fmt == RFC_FMT_DUAL;
  endsequence
  sequence s_regreg;
    s_dual ##0 (srcMode == RFC_AM_REG && dstMode == RFC_AM_REG && dstIdx != `RFC_IDX_PC);
  endsequence
  sequence s_badmode;
    s_dual ##0 (dstMode > RFC_AM_ABS || srcMode == RFC_AM_BAD);
  endsequence
  a_reset_clear: assert property (resetn && !$past(resetn) |-> !busWrite && !modeError && pcOut == 0 && statusOut == 0)
    else $error("outputs not cleared by reset");
  a_pc_step: assert property (s_regreg |-> ##2 (pcOut == $past(pcOut) + `RFC_PC_STEP))
    else $error("program counter did not step by one word");
  a_idle_pc_hold: assert property (s_idle [*3] |=> $stable(pcOut))
    else $error("program counter moved while idle");
  a_idle_no_bus: assert property (s_idle |=> !busWrite && !modeError)
    else $error("bus or error activity without an instruction");
  a_regreg_no_bus: assert property (s_regreg |=> !busWrite)
    else $error("register operation touched the bus");
  a_byte_flag: assert property (busWrite |-> busByte == $past(byteMode))
    else $error("bus width flag does not follow the instruction");
  a_byte_upper: assert property (busWrite && busByte |-> busWdata[15:8] == 8'h00)
    else $error("byte write carries upper data");
  a_mode_error: assert property (s_badmode |=> modeError)
    else $error("illegal mode not flagged");
  a_mode_legal: assert property (s_dual ##0 !(dstMode > RFC_AM_ABS || srcMode == RFC_AM_BAD) |=> !modeError)
    else $error("legal mode flagged");
  a_status_bits: assert property ((statusOut & ~`RFC_SR_MASK) == 16'h0000)
    else $error("status holds bits outside its field");
endmodule
bind rfc_core rfc_core_properties #(.DATA_W(DATA_W)) rfc_core_properties_inst (.clk_sys, .resetn, .instValid, .fmt,
  .byteMode, .dstIdx, .srcMode, .dstMode, .busWdata, .busWrite, .busByte, .pcOut, .statusOut, .modeError);
`default_nettype wire

//--- verification/rfc_mem_model.sv
/*
  memory and peripheral space on the far side of the core's buses.
  assumes byte addresses, bit 0 ignored; only sixteen words are decoded, the rest alias.
*/
`default_nettype none
module rfc_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWrite,
  input wire logic busByte,
  output logic [15:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cells [16];
  // non-zero fill so a stray read is never mistaken for a cleared word
  initial foreach (cells[i]) cells[i] = 16'hA5A5 ^ 16'(i);
  always @(posedge clk_sys) begin
    if (busWrite && busByte) cells[busAddr[4:1]][7:0] <= busWdata[7:0];
    else if (busWrite) cells[busAddr[4:1]] <= busWdata;
  end
  assign memRdata = cells[busAddr[4:1]];
endmodule
`default_nettype wire

//--- verification/tb_top.sv
/*
  self-checking bench for the register-file core with a memory model.
  assumes the checker is bound to rfc_core; stores go to word 0200.
*/
`default_nettype none
module tb_top
  import rfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {rfc_op_t o; logic b; logic [15:0] a; logic [15:0] d; logic [15:0] r;} rfc_row_t;
  logic clk_sys = 0, resetn = 0, instValid = 0, byteMode = 0, busWrite, busByte, modeError;
  rfc_fmt_t fmt = RFC_FMT_NONE;
  rfc_op_t op = RFC_OP_MOV;
  rfc_am_t srcMode = RFC_AM_REG, dstMode = RFC_AM_REG;
  logic [3:0] srcIdx = 0, dstIdx = 0;
  logic [1:0] cgSel = 0;
  logic [2:0] jumpCond = 0;
  logic [9:0] jumpOffset = 0;
  logic [15:0] extWord = 0, memRdata, busAddr, busWdata, pcOut, statusOut, seen, pc0;
  logic [15:0] cgExp [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
  int fails = 0, comparisons = 0, cycles = 0;
  rfc_row_t rows [9] = '{'{RFC_OP_MOV, 1'b0, 16'h1234, 16'h0000, 16'h1234},
    '{RFC_OP_MOV, 1'b1, 16'hABCD, 16'h0000, 16'h00CD}, '{RFC_OP_ADD, 1'b0, 16'h1234, 16'h0001, 16'h1235},
    '{RFC_OP_ADD, 1'b1, 16'h0001, 16'h12FF, 16'h0000}, '{RFC_OP_SUB, 1'b0, 16'h0003, 16'h0005, 16'h0002},
    '{RFC_OP_AND, 1'b0, 16'h0F0F, 16'hFF00, 16'h0F00}, '{RFC_OP_XOR, 1'b0, 16'hFFFF, 16'h1234, 16'hEDCB},
    '{RFC_OP_BIS, 1'b0, 16'h00F0, 16'h0F00, 16'h0FF0}, '{RFC_OP_BIC, 1'b0, 16'h0F00, 16'h0FF0, 16'h00F0}};
  rfc_core rfc_core_inst (.clk_sys, .resetn, .instValid, .fmt, .op, .byteMode, .srcIdx, .dstIdx, .srcMode, .dstMode,
    .cgSel, .extWord, .memRdata, .jumpCond, .jumpOffset, .busAddr, .busWdata, .busWrite, .busByte, .pcOut,
    .statusOut, .modeError);
  rfc_mem_model rfc_mem_model_inst (.clk_sys, .busAddr, .busWdata, .busWrite, .busByte, .memRdata);
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // leaves the request up, so back-to-back calls give one instruction per cycle
  task automatic issue(input rfc_fmt_t f, input rfc_op_t o, input logic b, input logic [3:0] si, input logic [3:0] di,
    input rfc_am_t sm, input rfc_am_t dm, input logic [1:0] cg, input logic [15:0] ew);
    instValid = 1'b1;
    fmt = f;
    op = o;
    byteMode = b;
    srcIdx = si;
    dstIdx = di;
    srcMode = sm;
    dstMode = dm;
    cgSel = cg;
    extWord = ew;
    @(posedge clk_sys);
    #2;
  endtask
  task automatic idle(input int n);
    instValid = 1'b0;
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic load(input logic [3:0] idx, input logic [15:0] val);
    issue(RFC_FMT_DUAL, RFC_OP_MOV, 1'b0, 4'h0, idx, RFC_AM_IMM, RFC_AM_REG, 2'h0, val);
  endtask
  task automatic store(input logic [3:0] idx, input logic b, output logic [15:0] val);
    issue(RFC_FMT_DUAL, RFC_OP_MOV, b, idx, 4'h0, RFC_AM_REG, RFC_AM_ABS, 2'h0, 16'h0200);
    instValid = 1'b0;
    for (int n = 0; n < 4 && busWrite !== 1'b1; n++) begin
      @(posedge clk_sys);
      #2;
    end
    check(busAddr, 16'h0200);
    check({15'h0000, busWrite}, 16'h0001);
    check({15'h0000, busByte}, {15'h0000, b});
    val = busWdata;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    check(pcOut, 16'h0000);
    foreach (rows[i]) begin
      load(4'h4, rows[i].a);
      load(4'h5, rows[i].d);
      issue(RFC_FMT_DUAL, rows[i].o, rows[i].b, 4'h4, 4'h5, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
      store(4'h5, 1'b0, seen);
      check(seen, rows[i].r);
    end
    for (int i = 4; i < 16; i++) load(4'(i), {4{4'(i)}});
    for (int i = 4; i < 16; i++) begin
      store(4'(i), 1'b0, seen);
      check(seen, {4{4'(i)}});
    end
    store(4'h4, 1'b1, seen);
    check(seen, 16'h0044);
    load(4'h3, 16'h5555);
    for (int c = 0; c < 4; c++) begin
      issue(RFC_FMT_DUAL, RFC_OP_MOV, 1'b0, 4'h3, 4'h6, RFC_AM_REG, RFC_AM_REG, 2'(c), 16'h0000);
      store(4'h6, 1'b0, seen);
      check(seen, cgExp[c]);
    end
    load(4'h4, 16'h0001);
    load(4'h5, 16'hFFFF);
    issue(RFC_FMT_DUAL, RFC_OP_ADD, 1'b0, 4'h4, 4'h5, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
    idle(2);
    check(statusOut & 16'h0107, 16'h0003);
    pc0 = pcOut;
    repeat (3) issue(RFC_FMT_DUAL, RFC_OP_ADD, 1'b0, 4'h4, 4'h7, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
    idle(3);
    check(pcOut, pc0 + 16'h0006);
    // zero flag is clear here: not-equal jumps by four words, equal falls through
    jumpCond = 3'h0;
    jumpOffset = 10'h004;
    issue(RFC_FMT_JUMP, RFC_OP_MOV, 1'b0, 4'h0, 4'h0, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
    jumpCond = 3'h1;
    issue(RFC_FMT_JUMP, RFC_OP_MOV, 1'b0, 4'h0, 4'h0, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
    idle(2);
    check(pcOut, pc0 + 16'h0012);
    issue(RFC_FMT_SINGLE, RFC_OP_SWPB, 1'b0, 4'h0, 4'h7, RFC_AM_REG, RFC_AM_REG, 2'h0, 16'h0000);
    store(4'h7, 1'b0, seen);
    check(seen, 16'h7A77);
    issue(RFC_FMT_DUAL, RFC_OP_MOV, 1'b0, 4'h9, 4'hA, RFC_AM_INC, RFC_AM_REG, 2'h0, 16'h0000);
    store(4'h9, 1'b0, seen);
    check(seen, 16'h999B);
    load(4'h7, 16'h0AAA);
    issue(RFC_FMT_NONE, RFC_OP_MOV, 1'b0, 4'h0, 4'h7, RFC_AM_IMM, RFC_AM_REG, 2'h0, 16'h5555);
    store(4'h7, 1'b0, seen);
    check(seen, 16'h0AAA);
    issue(RFC_FMT_DUAL, RFC_OP_MOV, 1'b0, 4'h4, 4'h5, RFC_AM_REG, RFC_AM_IND, 2'h0, 16'h0000);
    check({15'h0000, modeError}, 16'h0001);
    issue(RFC_FMT_DUAL, RFC_OP_MOV, 1'b0, 4'h4, 4'h5, RFC_AM_BAD, RFC_AM_REG, 2'h0, 16'h0000);
    check({15'h0000, modeError}, 16'h0001);
    load(4'h8, 16'h7777);
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    check(pcOut, 16'h0000);
    store(4'h8, 1'b0, seen);
    check(seen, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
